// ==== hw/dcp_pkg.sv ====
// Constants and types of the DMA channel core.
package dcp_pkg;
  localparam int unsigned NUM_CH             = 4;
  localparam int unsigned PRIO_W             = 2;
  localparam int unsigned ADDR_W             = 24;
  localparam int unsigned CNT_W              = 16;
  localparam int unsigned DATA_W             = 16;
  localparam int unsigned CODE_W             = 5;
  localparam int unsigned SYNC_STAGES        = 3;
  localparam logic [1:0]  PRIO_RESET         = 2'h0;
  localparam logic [4:0]  FAULT_NONE         = 5'h00;
  localparam logic [4:0]  FAULT_BUS          = 5'h09;
  localparam logic [4:0]  FAULT_EXT_ABORT    = 5'h10;
  localparam logic [4:0]  FAULT_COUNT        = 5'h0c;
  localparam logic [2:0]  BEC_NONE           = 3'h7;
  localparam logic [2:0]  BEC_HALT           = 3'h6;
  localparam logic [2:0]  BEC_BUS_ERR        = 3'h5;
  localparam logic [2:0]  BEC_RETRY          = 3'h4;
  localparam logic [2:0]  BEC_RELINQ         = 3'h3;
  localparam logic [2:0]  BEC_RESET          = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_STEP    = 24'h000002;
  localparam logic [ADDR_W-1:0] CHAIN_STEP   = 24'h000006;
  localparam logic [1:0]  BUF_DEPTH          = 2'h2;

  typedef enum logic [2:0] {
    DCP_IDLE,
    DCP_REQ,
    DCP_READ,
    DCP_WRITE,
    DCP_FETCH,
    DCP_WAIT_EXC,
    DCP_RELINQ
  } dcp_state_t;
endpackage : dcp_pkg

// ==== hw/dcp_core.sv ====
// Four-channel DMA arbitration, bus exception sequencing and error recovery.
`timescale 1ns/1ps
`default_nettype none

module dcp_core (
  input  wire logic                                    sys_clk_in,
  input  wire logic                                    rst_b_in,
  input  wire logic [dcp_pkg::NUM_CH-1:0]              chan_req_in,
  input  wire logic [dcp_pkg::NUM_CH*dcp_pkg::PRIO_W-1:0] channel_priority_reg_in,
  input  wire logic                                    prio_load_in,
  input  wire logic [dcp_pkg::NUM_CH-1:0]              start_operation_bit_in,
  input  wire logic [dcp_pkg::NUM_CH-1:0]              continue_bit_in,
  input  wire logic [dcp_pkg::NUM_CH-1:0]              chain_mode_in,
  input  wire logic [dcp_pkg::NUM_CH-1:0]              dual_dev_to_mem_in,
  input  wire logic [dcp_pkg::NUM_CH-1:0]              abort_mode_in,
  input  wire logic [dcp_pkg::NUM_CH*dcp_pkg::ADDR_W-1:0] init_addr_in,
  input  wire logic [dcp_pkg::NUM_CH*dcp_pkg::CNT_W-1:0]  init_count_in,
  input  wire logic [dcp_pkg::NUM_CH-1:0]              init_load_in,
  input  wire logic [dcp_pkg::NUM_CH-1:0]              fault_clear_in,
  input  wire logic [2:0]                              bus_exception_code_in,
  input  wire logic                                    peripheral_control_line_b_in,
  input  wire logic                                    done_b_in,
  input  wire logic                                    chip_select_b_in,
  input  wire logic                                    bus_grant_in,
  input  wire logic                                    bus_cycle_ack_in,
  input  wire logic                                    transfer_complete_strobe_in,
  input  wire logic [dcp_pkg::DATA_W-1:0]              read_data_in,
  input  wire logic                                    wr_ready_in,
  output logic                                         bus_request_out,
  output logic                                         bus_grant_acknowledge_out,
  output logic                                         bus_ctrl_oe_out,
  output logic                                         cycle_read_out,
  output logic                                         cycle_write_out,
  output logic                                         cycle_fetch_out,
  output logic [dcp_pkg::ADDR_W-1:0]                   cycle_addr_out,
  output logic [dcp_pkg::DATA_W-1:0]                   write_data_out,
  output logic                                         write_valid_out,
  output logic [1:0]                                   active_channel_out,
  output logic [dcp_pkg::NUM_CH*dcp_pkg::ADDR_W-1:0]   memory_pointer_reg_out,
  output logic [dcp_pkg::NUM_CH*dcp_pkg::ADDR_W-1:0]   device_pointer_reg_out,
  output logic [dcp_pkg::NUM_CH*dcp_pkg::ADDR_W-1:0]   chain_base_reg_out,
  output logic [dcp_pkg::NUM_CH*dcp_pkg::CNT_W-1:0]    memory_operand_counter_out,
  output logic [dcp_pkg::NUM_CH*dcp_pkg::CODE_W-1:0]   channel_fault_code_reg_out,
  output logic [dcp_pkg::NUM_CH-1:0]                   channel_running_flag_out,
  output logic [dcp_pkg::NUM_CH-1:0]                   operation_complete_flag_out,
  output logic [dcp_pkg::NUM_CH-1:0]                   fault_flag_out,
  output logic [dcp_pkg::NUM_CH-1:0]                   normal_device_termination_flag_out,
  output logic [dcp_pkg::NUM_CH-1:0]                   peripheral_line_transition_flag_out,
  output logic [dcp_pkg::NUM_CH-1:0]                   start_clear_out
);
  import dcp_pkg::*;

  dcp_state_t        state_reg, state_next;
  logic [2:0]        bec_s1_reg, bec_s2_reg, bec_s3_reg, bec_reg;
  logic [2:0]        sig_s1_reg, sig_s2_reg, sig_s3_reg;
  logic              pcl_low_reg, done_low_reg, cs_low_reg;
  logic [1:0]        prio_reg [NUM_CH];
  logic [ADDR_W-1:0] mem_ptr_reg [NUM_CH];
  logic [ADDR_W-1:0] dev_ptr_reg [NUM_CH];
  logic [ADDR_W-1:0] base_reg [NUM_CH];
  logic [CNT_W-1:0]  count_reg [NUM_CH];
  logic [CODE_W-1:0] code_reg [NUM_CH];
  logic [NUM_CH-1:0] run_reg, coc_reg, err_reg, ndt_reg, pct_reg, pend_err_reg;
  logic [1:0]        cur_reg, last_reg;
  logic              done_seen_reg, fetch_reg;
  logic              req_reg, ack_reg;
  logic [DATA_W-1:0] hold_reg;
  logic [DATA_W-1:0] buf_data_reg [2];
  logic [1:0]        buf_cnt_reg;
  logic              buf_rd_reg, buf_wr_reg;

  // Asynchronous inputs pass three stages.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bec_s1_reg <= BEC_NONE;
      bec_s2_reg <= BEC_NONE;
      bec_s3_reg <= BEC_NONE;
      sig_s1_reg <= 3'h7;
      sig_s2_reg <= 3'h7;
      sig_s3_reg <= 3'h7;
    end else begin
      bec_s1_reg <= bus_exception_code_in;
      bec_s2_reg <= bec_s1_reg;
      bec_s3_reg <= bec_s2_reg;
      sig_s1_reg <= {peripheral_control_line_b_in, done_b_in, chip_select_b_in};
      sig_s2_reg <= sig_s1_reg;
      sig_s3_reg <= sig_s2_reg;
    end
  end

  // A change counts once the last two stages agree.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bec_reg      <= BEC_NONE;
      pcl_low_reg  <= 1'b0;
      done_low_reg <= 1'b0;
      cs_low_reg   <= 1'b0;
    end else begin
      if (bec_s2_reg == bec_s3_reg) bec_reg <= bec_s3_reg;
      if (sig_s2_reg[2] == sig_s3_reg[2]) pcl_low_reg <= ~sig_s3_reg[2];
      if (sig_s2_reg[1] == sig_s3_reg[1]) done_low_reg <= ~sig_s3_reg[1];
      if (sig_s2_reg[0] == sig_s3_reg[0]) cs_low_reg <= ~sig_s3_reg[0];
    end
  end

  // Exception decode; the newest code that the last two stages agree on wins.
  wire exc_any    = (bec_reg != BEC_NONE);
  wire exc_relinq = (bec_reg == BEC_RELINQ);
  wire exc_buserr = (bec_reg == BEC_BUS_ERR);
  wire exc_reset  = (bec_reg == BEC_RESET);
  wire ext_abort  = pcl_low_reg & abort_mode_in[cur_reg];

  // Priority pick, round robin among equals.
  function automatic logic [2:0] dcp_pick(input logic [NUM_CH-1:0] req, input logic [1:0] last,
    input logic [7:0] prios);
    logic [1:0] best;
    logic [2:0] win;
    logic [1:0] idx;
    best = 2'h3;
    win  = 3'h0;
    for (int i = 0; i < NUM_CH; i++)
      if (req[i] && prios[2*i +: 2] < best) best = prios[2*i +: 2];
    for (int k = NUM_CH; k >= 1; k--) begin
      idx = 2'(last + 2'(k));
      if (req[idx] && prios[2*idx +: 2] == best) win = {1'b1, idx};
    end
    return win;
  endfunction : dcp_pick

  logic [7:0]        prio_flat;
  logic [NUM_CH-1:0] eligible;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_flat
      assign prio_flat[2*g +: 2] = prio_reg[g];
      assign eligible[g]         = chan_req_in[g] & run_reg[g] & ~pend_err_reg[g];
    end
  endgenerate
  wire [2:0] pick      = dcp_pick(eligible, last_reg, prio_flat);
  wire       buf_full  = (buf_cnt_reg == BUF_DEPTH);
  wire       buf_empty = (buf_cnt_reg == 2'h0);
  wire       term_now  = (count_reg[cur_reg] == CNT_W'(1)) | done_low_reg;

  // Request drops on chip select, else holds until acknowledge.
  wire want_bus = pick[2] & ~exc_any & (state_reg == DCP_IDLE || state_reg == DCP_REQ);
  wire req_next = cs_low_reg ? 1'b0 :
                  (req_reg & ~ack_reg) ? 1'b1 :
                  want_bus & ~ack_reg;

  // Transfer sequencer.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DCP_IDLE:     if (want_bus) state_next = DCP_REQ;
      DCP_REQ:      if (ack_reg) state_next = chain_mode_in[cur_reg] && fetch_reg ? DCP_FETCH :
                                              buf_wr_reg ? DCP_WRITE : DCP_READ;
      DCP_READ:     if (exc_relinq) state_next = DCP_RELINQ;
                    else if (exc_buserr || ext_abort) state_next = DCP_IDLE;
                    else if (exc_any) state_next = DCP_WAIT_EXC;
                    else if (transfer_complete_strobe_in && !buf_full) state_next = DCP_WRITE;
      DCP_WRITE:    if (exc_relinq) state_next = DCP_RELINQ;
                    else if (exc_buserr) state_next = DCP_IDLE;
                    else if (ext_abort && !done_seen_reg) state_next = DCP_IDLE;
                    else if (exc_any) state_next = DCP_WAIT_EXC;
                    else if (bus_cycle_ack_in && !buf_empty) state_next = DCP_IDLE;
      DCP_FETCH:    if (exc_buserr || ext_abort) state_next = DCP_IDLE;
                    else if (bus_cycle_ack_in) state_next = DCP_READ;
      DCP_WAIT_EXC: if (exc_relinq) state_next = DCP_RELINQ;
                    else if (exc_buserr) state_next = DCP_IDLE;
                    else if (!exc_any) state_next = buf_wr_reg ? DCP_WRITE : DCP_READ;
      DCP_RELINQ:   if (exc_buserr) state_next = DCP_IDLE;
                    else if (!exc_any) state_next = DCP_REQ;
    endcase
    if (exc_reset) state_next = DCP_IDLE;
  end

  wire in_cycle  = (state_reg == DCP_READ) | (state_reg == DCP_WRITE) | (state_reg == DCP_FETCH);
  wire fail_now  = in_cycle & (exc_buserr | (ext_abort & ~(state_reg == DCP_WRITE && done_seen_reg)));
  wire fail_code = exc_buserr;
  wire ok_write  = (state_reg == DCP_WRITE) & bus_cycle_ack_in & ~exc_any & ~fail_now & ~buf_empty;
  wire ok_fetch  = (state_reg == DCP_FETCH) & bus_cycle_ack_in & ~fail_now;
  wire rd_take   = (state_reg == DCP_READ) & transfer_complete_strobe_in & ~exc_any & ~fail_now & ~buf_full;

  // Sequencer state and bus ownership.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg     <= DCP_IDLE;
      req_reg       <= 1'b0;
      ack_reg       <= 1'b0;
      cur_reg       <= 2'h0;
      last_reg      <= 2'h3;
      done_seen_reg <= 1'b0;
      fetch_reg     <= 1'b0;
      hold_reg      <= '0;
      buf_cnt_reg   <= 2'h0;
      buf_wr_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_reg   <= req_next;
      ack_reg   <= bus_grant_in & (req_reg | ack_reg) & (state_next != DCP_IDLE)
                   & (state_next != DCP_RELINQ) & ~exc_reset;
      if (state_reg == DCP_IDLE && want_bus) begin
        cur_reg       <= pick[1:0];
        done_seen_reg <= 1'b0;
        fetch_reg     <= chain_mode_in[pick[1:0]] & (count_reg[pick[1:0]] == '0);
      end
      if (ok_write) last_reg <= cur_reg;
      if (ok_fetch) fetch_reg <= 1'b0;
      if (rd_take) begin
        hold_reg      <= read_data_in;
        done_seen_reg <= done_low_reg;
        buf_wr_reg    <= 1'b1;
      end
      if (ok_write || fail_now) buf_wr_reg <= 1'b0;
      // Held operand is only replaced by a DMA read, never by host access.
      buf_cnt_reg <= 2'(buf_cnt_reg + {1'b0, rd_take} - {1'b0, ok_write | (fail_now & ~buf_empty)});
    end
  end

  // Two-entry operand buffer.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      buf_data_reg[0] <= '0;
      buf_data_reg[1] <= '0;
      buf_rd_reg      <= 1'b0;
    end else begin
      if (rd_take) buf_data_reg[buf_rd_reg ^ buf_cnt_reg[0]] <= read_data_in;
      if (ok_write || (fail_now && !buf_empty)) buf_rd_reg <= ~buf_rd_reg;
    end
  end

  // Per channel registers.
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      wire mine     = (cur_reg == 2'(g));
      wire fail_ch  = mine & fail_now;
      wire start_ok = start_operation_bit_in[g] & ~run_reg[g] & ~pend_err_reg[g] & ~err_reg[g];
      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          prio_reg[g]     <= PRIO_RESET;
          mem_ptr_reg[g]  <= '0;
          dev_ptr_reg[g]  <= '0;
          base_reg[g]     <= '0;
          count_reg[g]    <= '0;
          code_reg[g]     <= FAULT_NONE;
          run_reg[g]      <= 1'b0;
          coc_reg[g]      <= 1'b0;
          err_reg[g]      <= 1'b0;
          ndt_reg[g]      <= 1'b0;
          pct_reg[g]      <= 1'b0;
          pend_err_reg[g] <= 1'b0;
        end else begin
          if (exc_reset) prio_reg[g] <= PRIO_RESET;
          else if (prio_load_in) prio_reg[g] <= channel_priority_reg_in[2*g +: 2];
          if (init_load_in[g] && !run_reg[g]) begin
            mem_ptr_reg[g] <= init_addr_in[ADDR_W*g +: ADDR_W];
            dev_ptr_reg[g] <= init_addr_in[ADDR_W*g +: ADDR_W];
            base_reg[g]    <= init_addr_in[ADDR_W*g +: ADDR_W];
            count_reg[g]   <= init_count_in[CNT_W*g +: CNT_W];
          end
          if (mine && ok_write) begin
            mem_ptr_reg[g] <= mem_ptr_reg[g] + ADDR_STEP;
            dev_ptr_reg[g] <= dev_ptr_reg[g] + ADDR_STEP;
            count_reg[g]   <= count_reg[g] - CNT_W'(1);
          end
          // A failed fetch leaves the chain pointer on that entry.
          if (mine && ok_fetch) begin
            base_reg[g]  <= base_reg[g] + CHAIN_STEP;
            count_reg[g] <= read_data_in;
          end
          // An abort may leave prior values unrestored.
          if (pcl_low_reg && mine) pct_reg[g] <= 1'b1;
          if (start_ok) run_reg[g] <= 1'b1;
          if (mine && ok_write && term_now) begin
            run_reg[g] <= 1'b0;
            coc_reg[g] <= 1'b1;
            if (done_low_reg || done_seen_reg) ndt_reg[g] <= 1'b1;
          end
          if (start_operation_bit_in[g] && (err_reg[g] || pend_err_reg[g])) pend_err_reg[g] <= 1'b1;
          if (fault_clear_in[g]) begin
            err_reg[g]      <= 1'b0;
            pend_err_reg[g] <= 1'b0;
            code_reg[g]     <= FAULT_NONE;
          end
          if (fail_ch) begin
            run_reg[g] <= 1'b0;
            coc_reg[g] <= 1'b1;
            err_reg[g] <= 1'b1;
            if (err_reg[g]) pend_err_reg[g] <= 1'b1;
            else code_reg[g] <= fail_code ? FAULT_BUS : FAULT_EXT_ABORT;
          end
        end
      end
      assign memory_pointer_reg_out[ADDR_W*g +: ADDR_W]     = mem_ptr_reg[g];
      assign device_pointer_reg_out[ADDR_W*g +: ADDR_W]     = dev_ptr_reg[g];
      assign chain_base_reg_out[ADDR_W*g +: ADDR_W]         = base_reg[g];
      assign memory_operand_counter_out[CNT_W*g +: CNT_W]   = count_reg[g];
      assign channel_fault_code_reg_out[CODE_W*g +: CODE_W] = code_reg[g];
      assign start_clear_out[g] = fail_ch | pend_err_reg[g];
    end
  endgenerate

  // Outputs.
  assign bus_request_out = req_reg;
  assign bus_grant_acknowledge_out = ack_reg;
  assign bus_ctrl_oe_out = ack_reg & (state_reg != DCP_RELINQ);
  assign cycle_read_out = ack_reg & (state_reg == DCP_READ);
  assign cycle_write_out = ack_reg & (state_reg == DCP_WRITE);
  assign cycle_fetch_out = ack_reg & (state_reg == DCP_FETCH);
  assign cycle_addr_out = state_reg == DCP_FETCH ? base_reg[cur_reg] :
    state_reg == DCP_WRITE ? mem_ptr_reg[cur_reg] : dev_ptr_reg[cur_reg];
  assign write_data_out = buf_data_reg[buf_rd_reg];
  assign write_valid_out = cycle_write_out & ~buf_empty & wr_ready_in;
  assign active_channel_out = cur_reg;
  assign channel_running_flag_out = run_reg;
  assign operation_complete_flag_out = coc_reg;
  assign fault_flag_out = err_reg;
  assign normal_device_termination_flag_out = ndt_reg;
  assign peripheral_line_transition_flag_out = pct_reg;
endmodule : dcp_core

`default_nettype wire

// ==== sim/dcp_chk.sv ====
// Assertions on the core's ports.
`timescale 1ns/1ps
`default_nettype none
module dcp_chk (
  input wire logic        sys_clk_in,
  input wire logic        rst_b_in,
  input wire logic        chip_select_b_in,
  input wire logic [2:0]  bus_exception_code_in,
  input wire logic [3:0]  init_load_in,
  input wire logic [3:0]  fault_clear_in,
  input wire logic        bus_request_out,
  input wire logic        bus_grant_acknowledge_out,
  input wire logic        bus_ctrl_oe_out,
  input wire logic [95:0] memory_pointer_reg_out,
  input wire logic [63:0] memory_operand_counter_out,
  input wire logic [19:0] channel_fault_code_reg_out,
  input wire logic [3:0]  channel_running_flag_out,
  input wire logic [3:0]  operation_complete_flag_out,
  input wire logic [3:0]  fault_flag_out
);
  import dcp_pkg::*;
  logic [2:0] calm_reg;
  // Quiet cycles since chip select or an exception.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      calm_reg <= 3'h0;
    end else begin
      calm_reg <= (!chip_select_b_in || bus_exception_code_in != BEC_NONE) ? 3'h0 : calm_reg + {2'h0, calm_reg != 3'h7};
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_cs_hit;
    !chip_select_b_in && bus_request_out && !bus_grant_acknowledge_out;
  endsequence
  sequence s_relinq;
    (bus_exception_code_in == BEC_RELINQ) [*8];
  endsequence
  AST_REQ_HELD: assert property ($fell(bus_request_out) && calm_reg == 3'h7 |->
    bus_grant_acknowledge_out || $past(bus_grant_acknowledge_out)) else $error("request dropped early");
  AST_CS_DROP: assert property (s_cs_hit |-> ##[1:6] (!bus_request_out || bus_grant_acknowledge_out))
    else $error("request kept under chip select");
  AST_RELINQ: assert property (s_relinq |-> !bus_grant_acknowledge_out && !bus_ctrl_oe_out)
    else $error("bus kept during relinquish");
  // Per channel recovery relations.
  for (genvar i = 0; i < 4; i++) begin : g_ch
    wire logic [23:0] ptr  = memory_pointer_reg_out[i*24 +: 24];
    wire logic [15:0] cnt  = memory_operand_counter_out[i*16 +: 16];
    wire logic [4:0]  code = channel_fault_code_reg_out[i*5 +: 5];
    AST_FIRST_KEPT: assert property (code != FAULT_NONE && !fault_clear_in[i] && bus_exception_code_in[2] |=>
      $stable(code)) else $error("fault code overwritten");
    AST_ERR_STOP: assert property ($rose(fault_flag_out[i]) |-> !channel_running_flag_out[i] &&
      operation_complete_flag_out[i] && code != FAULT_NONE) else $error("error flags wrong");
    AST_FAIL_HOLD: assert property ($rose(fault_flag_out[i]) && code != FAULT_EXT_ABORT |->
      $stable(ptr) && $stable(cnt)) else $error("pointers moved on error");
    AST_STEP: assert property (cnt + 16'h0001 == $past(cnt) && !$past(init_load_in[i]) |->
      ptr == $past(ptr) + ADDR_STEP) else $error("pointer step wrong");
    AST_NO_START: assert property (fault_flag_out[i] && !channel_running_flag_out[i] && !fault_clear_in[i] |=>
      !channel_running_flag_out[i]) else $error("channel started with error");
  end
endmodule : dcp_chk
`default_nettype wire

// ==== sim/dcp_bus_model.sv ====
// Partner model: bus grant and slow or fast cycles.
`timescale 1ns/1ps
`default_nettype none
module dcp_bus_model (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        slow_in,
  input  wire logic        hold_grant_in,
  input  wire logic        bus_request_in,
  input  wire logic        grant_ack_in,
  input  wire logic        cycle_read_in,
  input  wire logic        cycle_write_in,
  input  wire logic [15:0] write_data_in,
  output logic             bus_grant_out,
  output logic             cycle_ack_out,
  output logic             strobe_out,
  output logic [15:0]      read_data_out,
  output logic             wr_ready_out,
  output logic [15:0]      last_read_out,
  output logic [15:0]      last_write_out
);
  logic [3:0] wait_reg;
  wire logic  hit = wait_reg == (slow_in ? 4'hc : 4'h2);
  // Read data is valid only with the strobe.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {bus_grant_out, cycle_ack_out, strobe_out, wr_ready_out, wait_reg} <= '0;
      {read_data_out, last_read_out, last_write_out} <= '0;
    end else begin
      bus_grant_out <= (bus_request_in | grant_ack_in) & ~hold_grant_in;
      wait_reg <= (cycle_read_in | cycle_write_in) & ~hit ? wait_reg + 4'h1 : 4'h0;
      strobe_out <= cycle_read_in & hit;
      cycle_ack_out <= cycle_write_in & hit;
      read_data_out <= (cycle_read_in & hit) ? last_read_out + 16'h1357 : ~read_data_out;
      last_read_out <= (cycle_read_in & hit) ? last_read_out + 16'h1357 : last_read_out;
      last_write_out <= (cycle_write_in & cycle_ack_out) ? write_data_in : last_write_out;
      wr_ready_out <= ~slow_in | wait_reg[1];
    end
  end
endmodule : dcp_bus_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the DMA channel core.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dcp_pkg::*;
  logic        sys_clk_in = 1'b0, rst_b_in = 1'b0, prio_load_in = 1'b0, chip_select_b_in = 1'b1, slow = 1'b0, hold = 1'b0;
  logic        bus_grant_in, bus_cycle_ack_in, transfer_complete_strobe_in, wr_ready_in;
  logic        bus_request_out, bus_grant_acknowledge_out, bus_ctrl_oe_out, cycle_read_out, cycle_write_out;
  logic [2:0]  bus_exception_code_in = BEC_NONE;
  logic [1:0]  active_channel_out;
  logic [7:0]  channel_priority_reg_in = 8'h00;
  logic [15:0] read_data_in, write_data_out, last_rd, last_wr;
  logic [19:0] channel_fault_code_reg_out;
  logic [95:0] init_addr_in = {24'h000400, 24'h000300, 24'h000200, 24'h000100}, memory_pointer_reg_out;
  logic [63:0] init_count_in = {4{16'h0010}}, memory_operand_counter_out;
  logic [3:0]  chan_req_in = 4'h0, start_operation_bit_in = 4'h0, init_load_in = 4'h0, fault_clear_in = 4'h0;
  logic [3:0]  dual_dev_to_mem_in = 4'h5, abort_mode_in = 4'h2, channel_running_flag_out, fault_flag_out;
  logic [3:0]  operation_complete_flag_out;
  int          err_count = 0, comparisons = 0, cycles = 0;
  dcp_core u_dcp_core (.sys_clk_in, .rst_b_in, .chan_req_in, .channel_priority_reg_in, .prio_load_in,
    .start_operation_bit_in, .continue_bit_in(4'h0), .chain_mode_in(4'h0), .dual_dev_to_mem_in, .abort_mode_in,
    .init_addr_in, .init_count_in, .init_load_in, .fault_clear_in, .bus_exception_code_in,
    .peripheral_control_line_b_in(1'b1), .done_b_in(1'b1), .chip_select_b_in, .bus_grant_in, .bus_cycle_ack_in,
    .transfer_complete_strobe_in, .read_data_in, .wr_ready_in, .bus_request_out, .bus_grant_acknowledge_out,
    .bus_ctrl_oe_out, .cycle_read_out, .cycle_write_out, .cycle_fetch_out(), .cycle_addr_out(), .write_data_out,
    .write_valid_out(), .active_channel_out, .memory_pointer_reg_out, .device_pointer_reg_out(),
    .chain_base_reg_out(), .memory_operand_counter_out, .channel_fault_code_reg_out, .channel_running_flag_out,
    .operation_complete_flag_out, .fault_flag_out, .normal_device_termination_flag_out(),
    .peripheral_line_transition_flag_out(), .start_clear_out());
  dcp_bus_model u_dcp_bus_model (.sys_clk_in, .rst_b_in, .slow_in(slow), .hold_grant_in(hold),
    .bus_request_in(bus_request_out), .grant_ack_in(bus_grant_acknowledge_out), .cycle_read_in(cycle_read_out),
    .cycle_write_in(cycle_write_out), .write_data_in(write_data_out), .bus_grant_out(bus_grant_in),
    .cycle_ack_out(bus_cycle_ack_in), .strobe_out(transfer_complete_strobe_in), .read_data_out(read_data_in),
    .wr_ready_out(wr_ready_in), .last_read_out(last_rd), .last_write_out(last_wr));
  // Clock and a hang guard.
  always #12.5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic check(input string name, input logic [23:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : tick
  task automatic till(ref logic s, input logic v);
    for (int k = 0; k < 400 && s !== v; k++) @(negedge sys_clk_in);
  endtask : till
  // One operand on channel zero, then pointer and count checks.
  task automatic one_xfer(input logic [23:0] ptr, cnt);
    tick(1);
    chan_req_in[0] <= 1'b1;
    till(bus_grant_acknowledge_out, 1'b1);
    tick(1);
    chan_req_in[0] <= 1'b0;
    till(bus_grant_acknowledge_out, 1'b0);
    tick(3);
    check("ptr0", memory_pointer_reg_out[23:0], ptr);
    check("cnt0", memory_operand_counter_out[15:0], cnt);
    check("wdata", last_wr, last_rd);
  endtask : one_xfer
  // Bus error in a slow read, then a refused restart and a clear.
  task automatic t_buserr;
    tick(1);
    slow <= 1'b1;
    chan_req_in[0] <= 1'b1;
    till(cycle_read_out, 1'b1);
    tick(1);
    bus_exception_code_in <= BEC_BUS_ERR;
    tick(6);
    bus_exception_code_in <= BEC_NONE;
    tick(6);
    check("fault0", fault_flag_out[0], 1'b1);
    check("code0", channel_fault_code_reg_out[4:0], FAULT_BUS);
    check("ptr0", memory_pointer_reg_out[23:0], 24'h000102);
    check("cnt0", memory_operand_counter_out[15:0], 16'h000f);
    tick(20);
    check("run0", channel_running_flag_out[0], 1'b0);
    check("code0", channel_fault_code_reg_out[4:0], FAULT_BUS);
    chan_req_in[0] <= 1'b0;
    slow <= 1'b0;
    fault_clear_in[0] <= 1'b1;
    start_operation_bit_in[0] <= 1'b0;
    tick(1);
    fault_clear_in[0] <= 1'b0;
    start_operation_bit_in[0] <= 1'b1;
    tick(2);
  endtask : t_buserr
  // Relinquish in a write, host access, then the held operand is written.
  task automatic t_relinq;
    tick(1);
    slow <= 1'b1;
    chan_req_in[0] <= 1'b1;
    till(cycle_write_out, 1'b1);
    tick(1);
    bus_exception_code_in <= BEC_RELINQ;
    tick(9);
    check("ack", bus_grant_acknowledge_out, 1'b0);
    check("oe", bus_ctrl_oe_out, 1'b0);
    chip_select_b_in <= 1'b0;
    tick(3);
    chip_select_b_in <= 1'b1;
    tick(2);
    bus_exception_code_in <= BEC_NONE;
    slow <= 1'b0;
    till(bus_grant_acknowledge_out, 1'b1);
    tick(1);
    chan_req_in[0] <= 1'b0;
    till(bus_grant_acknowledge_out, 1'b0);
    tick(3);
    check("held", last_wr, last_rd);
    check("ptr0", memory_pointer_reg_out[23:0], 24'h000104);
  endtask : t_relinq
  // Chip select while the request waits for a grant withdraws it.
  task automatic t_cs;
    tick(1);
    hold <= 1'b1;
    chan_req_in[0] <= 1'b1;
    till(bus_request_out, 1'b1);
    tick(1);
    chip_select_b_in <= 1'b0;
    tick(7);
    check("breq", bus_request_out, 1'b0);
    chip_select_b_in <= 1'b1;
    hold <= 1'b0;
    chan_req_in[0] <= 1'b0;
    tick(8);
    one_xfer(24'h000106, 24'h00000d);
  endtask : t_cs
  // Priorities 3,0,1,0 for channels 0..3, requests from channels 0 and 2, then 1 and 3.
  task automatic t_prio;
    logic [1:0] c [4];
    tick(1);
    channel_priority_reg_in <= 8'h13;
    prio_load_in <= 1'b1;
    tick(1);
    prio_load_in <= 1'b0;
    chan_req_in <= 4'h5;
    for (int k = 0; k < 4; k++) begin
      till(bus_grant_acknowledge_out, 1'b0);
      till(bus_grant_acknowledge_out, 1'b1);
      c[k] = active_channel_out;
      tick(1);
      chan_req_in <= (k == 3) ? 4'h0 : 4'ha;
    end
    check("first", c[0], 2'h2);
    check("rot", c[1] ^ c[2], 2'h2);
    check("rot2", c[3], c[1]);
  endtask : t_prio
  initial begin
    tick(6);
    rst_b_in <= 1'b1;
    tick(4);
    init_load_in <= 4'hf;
    tick(1);
    init_load_in <= 4'h0;
    start_operation_bit_in <= 4'hf;
    tick(2);
    one_xfer(24'h000102, 24'h00000f);
    t_buserr();
    t_relinq();
    t_cs();
    t_prio();
    stop_test();
  end
endmodule : testbench
bind dcp_core dcp_chk u_dcp_chk (.sys_clk_in, .rst_b_in, .chip_select_b_in, .bus_exception_code_in, .init_load_in,
  .fault_clear_in, .bus_request_out, .bus_grant_acknowledge_out, .bus_ctrl_oe_out, .memory_pointer_reg_out,
  .memory_operand_counter_out, .channel_fault_code_reg_out, .channel_running_flag_out,
  .operation_complete_flag_out, .fault_flag_out);
`default_nettype wire
